// >>> rtl/opp_edge_det.sv
// Rise and fall detector for a group of synchronous strobes
`timescale 1ns/10ps
`default_nettype none
module opp_edge_det #(
  parameter int N = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Watched levels
  input wire logic [N-1:0] sig,
  // One-cycle edge pulses
  output logic [N-1:0] rise,
  output logic [N-1:0] fall
);

  // ----------------------------------------------------------------
  // Previous level
  // ----------------------------------------------------------------
  logic [N-1:0] prev_q; // Level seen at the last edge
  logic [N-1:0] prev_d;

  // Next value is the current level
  always_comb begin
    prev_d = sig;
  end

  // Reset to the present level, so no false edge follows reset whatever the idle level
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_q <= sig;
    end else begin
      prev_q <= prev_d;
    end
  end

  // Per-bit edge decode
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign rise[i] = sig[i] & ~prev_q[i];
    assign fall[i] = ~sig[i] & prev_q[i];
  end

endmodule
`default_nettype wire

// >>> rtl/opp_pkg.sv
// Constants and types shared by the programming port files
`default_nettype none
package opp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;           // 40 MHz clock
  localparam int ENTRY_TIME_NS = 1000;         // Least time entry levels must hold
  localparam int ENTRY_CYCLES = (ENTRY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] ENTRY_CNT_MAX = 6'(ENTRY_CYCLES - 1);
  localparam logic [5:0] ENTRY_CNT_ZERO = 6'h00;
  localparam logic [5:0] ENTRY_CNT_ONE = 6'h01;

  // ----------------------------------------------------------------
  // Widths and layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;                  // Code memory address A13..A0
  localparam int HI_W = 6;                     // High address A13..A8
  localparam int DATA_W = 8;
  localparam int LOCK_W = 2;                   // Lock bits on D1,D0
  localparam int NUM_STB = 3;                  // Strobes watched for edges
  localparam int STB_ALE = 0;                  // High address latch strobe
  localparam int STB_WR = 1;                   // Program write strobe
  localparam int STB_RD = 2;                   // Program read strobe

  // ----------------------------------------------------------------
  // Reset values and read contents
  // ----------------------------------------------------------------
  localparam logic [LOCK_W-1:0] LOCK_RESET = 2'h3;    // Both bits unprogrammed
  localparam logic [HI_W-1:0] HI_RESET = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 14'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [DATA_W-LOCK_W-1:0] LOCK_PAD = 6'h00;  // Upper lock read bits
  localparam logic [DATA_W-1:0] VER_ADDR0 = 8'hfc;
  localparam logic [DATA_W-1:0] VER_ADDR1 = 8'hfd;
  localparam logic [DATA_W-1:0] VER_ADDR2 = 8'hfe;
  localparam logic [DATA_W-1:0] VER_BYTE0 = 8'h5a;    // Value is arbitrary
  localparam logic [DATA_W-1:0] VER_BYTE1 = 8'h6b;    // Value is arbitrary
  localparam logic [DATA_W-1:0] VER_BYTE2 = 8'h7c;    // Value is arbitrary

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RSVD = 2'b00,
    MODE_VERSION = 2'b01,
    MODE_LOCK = 2'b10,
    MODE_MEM = 2'b11
  } opp_access_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ENTRY = 2'b01,
    ST_ACTIVE = 2'b10
  } opp_state_type;

endpackage
`default_nettype wire

// >>> rtl/opp_port.sv
// Device-side programming port of the one-time-programmable code memory
`timescale 1ns/10ps
`default_nettype none
module opp_port (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Mode entry pins
  input wire logic RESET_PIN,
  input wire logic CODE_FETCH_STROBE_PIN,
  input wire logic PROGRAMMING_VOLTAGE_PIN,
  input wire logic PROGRAMMING_VOLTAGE_HIGH,
  // Access control pins
  input wire logic ACCESS_SELECT_LOW,
  input wire logic ACCESS_SELECT_HIGH,
  input wire logic HIGH_ADDRESS_LATCH_STROBE,
  input wire logic PROGRAM_WRITE_STROBE_N,
  input wire logic PROGRAM_READ_STROBE_N,
  // Address and data pins
  input wire logic [opp_pkg::DATA_W-1:0] ADDRESS_BUS_PORT,
  input wire logic [opp_pkg::DATA_W-1:0] DATA_BUS_PORT_IN,
  output logic [opp_pkg::DATA_W-1:0] DATA_BUS_PORT_OUT,
  output logic DATA_BUS_PORT_OE,
  // Code memory array
  output logic [opp_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [opp_pkg::DATA_W-1:0] MEM_WDATA,
  output logic MEM_WRITE,
  input wire logic [opp_pkg::DATA_W-1:0] MEM_RDATA,
  // Status
  output logic PROGRAM_WRITE_STROBE_MODE_ACTIVE,
  output logic [opp_pkg::LOCK_W-1:0] LOCK_BITS
);

  // ----------------------------------------------------------------
  // Strobe edges
  // ----------------------------------------------------------------
  logic [opp_pkg::NUM_STB-1:0] stb_lvl; // Strobe levels
  logic [opp_pkg::NUM_STB-1:0] stb_rise; // Rising edges
  logic [opp_pkg::NUM_STB-1:0] stb_fall; // Falling edges

  assign stb_lvl[opp_pkg::STB_ALE] = HIGH_ADDRESS_LATCH_STROBE;
  assign stb_lvl[opp_pkg::STB_WR] = PROGRAM_WRITE_STROBE_N;
  assign stb_lvl[opp_pkg::STB_RD] = PROGRAM_READ_STROBE_N;

  opp_edge_det #(.N(opp_pkg::NUM_STB)) u_edge (
    .clk(CLK),
    .nrst(NRST),
    .sig(stb_lvl),
    .rise(stb_rise),
    .fall(stb_fall)
  );

  // ----------------------------------------------------------------
  // Mode entry state machine
  // ----------------------------------------------------------------
  opp_pkg::opp_state_type state_q; // Programming mode state
  opp_pkg::opp_state_type state_d;
  logic [5:0] cnt_q; // Cycles the entry levels have held
  logic [5:0] cnt_d;
  logic entry_ok; // All entry levels present
  logic active; // Accesses allowed

  // Reset high, fetch strobe low, write strobe low, voltage pin low
  assign entry_ok = RESET_PIN & ~CODE_FETCH_STROBE_PIN & ~PROGRAM_WRITE_STROBE_N &
                    ~PROGRAMMING_VOLTAGE_PIN & ~PROGRAMMING_VOLTAGE_HIGH;
  assign active = (state_q == opp_pkg::ST_ACTIVE);

  // Next state; a glitch in the entry levels restarts the count
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      opp_pkg::ST_IDLE: begin
        cnt_d = opp_pkg::ENTRY_CNT_ZERO;
        if (entry_ok) begin
          state_d = opp_pkg::ST_ENTRY;
        end
      end
      opp_pkg::ST_ENTRY: begin
        if (!entry_ok) begin
          state_d = opp_pkg::ST_IDLE; // Broken entry, start over
        end else if (cnt_q == opp_pkg::ENTRY_CNT_MAX) begin
          state_d = opp_pkg::ST_ACTIVE;
        end else begin
          cnt_d = cnt_q + opp_pkg::ENTRY_CNT_ONE;
        end
      end
      opp_pkg::ST_ACTIVE: begin
        // Leaving reset or raising the fetch strobe ends the mode
        if (!RESET_PIN || CODE_FETCH_STROBE_PIN) begin
          state_d = opp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = opp_pkg::ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_q <= opp_pkg::ST_IDLE;
      cnt_q <= opp_pkg::ENTRY_CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Address and access mode latches
  // ----------------------------------------------------------------
  opp_pkg::opp_access_type mode_q; // Selected access mode
  opp_pkg::opp_access_type mode_d;
  logic [opp_pkg::HI_W-1:0] hi_q; // Latched A13..A8
  logic [opp_pkg::HI_W-1:0] hi_d;
  logic [opp_pkg::ADDR_W-1:0] addr_q; // Address to the array
  logic [opp_pkg::ADDR_W-1:0] addr_d;

  // Mode taken at latch strobe rise, high address at its fall
  always_comb begin
    mode_d = mode_q;
    hi_d = hi_q;
    addr_d = {hi_q, ADDRESS_BUS_PORT};
    if (!active) begin
      mode_d = opp_pkg::MODE_RSVD; // Safe code until a select is latched
    end else begin
      if (stb_rise[opp_pkg::STB_ALE]) begin
        mode_d = opp_pkg::opp_access_type'({ACCESS_SELECT_HIGH, ACCESS_SELECT_LOW});
      end
      if (stb_fall[opp_pkg::STB_ALE]) begin
        hi_d = ADDRESS_BUS_PORT[opp_pkg::HI_W-1:0];
      end
    end
  end

  // Latch registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      mode_q <= opp_pkg::MODE_RSVD;
      hi_q <= opp_pkg::HI_RESET;
      addr_q <= opp_pkg::ADDR_RESET;
    end else begin
      mode_q <= mode_d;
      hi_q <= hi_d;
      addr_q <= addr_d;
    end
  end

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  logic wr_fire; // Qualified write strobe edge
  logic we_q; // Array write pulse
  logic we_d;
  logic [opp_pkg::DATA_W-1:0] wdata_q; // Byte to program
  logic [opp_pkg::DATA_W-1:0] wdata_d;
  logic [opp_pkg::LOCK_W-1:0] lock_q; // Lock bits, one means unprogrammed
  logic [opp_pkg::LOCK_W-1:0] lock_d;

  // Writes need the strobe edge, read strobe idle and the high voltage
  assign wr_fire = active & stb_fall[opp_pkg::STB_WR] & PROGRAM_READ_STROBE_N &
                   PROGRAMMING_VOLTAGE_HIGH;

  // Program cells only go from one to zero, so lock bits AND in
  always_comb begin
    we_d = 1'b0;
    wdata_d = wdata_q;
    lock_d = lock_q;
    if (wr_fire) begin
      case (mode_q)
        opp_pkg::MODE_MEM: begin
          we_d = 1'b1;
          wdata_d = DATA_BUS_PORT_IN;
        end
        opp_pkg::MODE_LOCK: begin
          lock_d = lock_q & DATA_BUS_PORT_IN[opp_pkg::LOCK_W-1:0];
        end
        default: begin
          // Version and reserved codes change nothing
          we_d = 1'b0;
        end
      endcase
    end
  end

  // Write registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      we_q <= 1'b0;
      wdata_q <= opp_pkg::DATA_RESET;
      lock_q <= opp_pkg::LOCK_RESET;
    end else begin
      we_q <= we_d;
      wdata_q <= wdata_d;
      lock_q <= lock_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic rd_on; // Device owns port 0
  logic [opp_pkg::DATA_W-1:0] rd_q; // Byte shown on port 0
  logic [opp_pkg::DATA_W-1:0] rd_d;
  logic [opp_pkg::DATA_W-1:0] ver_byte; // Version byte for the address

  // Only the read strobe hands port 0 to the device
  assign rd_on = active & ~PROGRAM_READ_STROBE_N & PROGRAM_WRITE_STROBE_N &
                 (mode_q != opp_pkg::MODE_RSVD);

  // Unknown version addresses read as zero
  always_comb begin
    case (addr_q[opp_pkg::DATA_W-1:0])
      opp_pkg::VER_ADDR0: ver_byte = opp_pkg::VER_BYTE0;
      opp_pkg::VER_ADDR1: ver_byte = opp_pkg::VER_BYTE1;
      opp_pkg::VER_ADDR2: ver_byte = opp_pkg::VER_BYTE2;
      default: ver_byte = opp_pkg::DATA_RESET;
    endcase
  end

  // Prefetch while the read strobe is high, freeze while it is low,
  // so the byte is steady for the whole pulse
  always_comb begin
    rd_d = rd_q;
    if (PROGRAM_READ_STROBE_N) begin
      case (mode_q)
        opp_pkg::MODE_MEM: rd_d = MEM_RDATA;
        opp_pkg::MODE_LOCK: rd_d = {opp_pkg::LOCK_PAD, lock_q};
        opp_pkg::MODE_VERSION: rd_d = ver_byte;
        default: rd_d = opp_pkg::DATA_RESET;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rd_q <= opp_pkg::DATA_RESET;
    end else begin
      rd_q <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign DATA_BUS_PORT_OUT = rd_q;
  assign DATA_BUS_PORT_OE = rd_on;
  assign MEM_ADDR = addr_q;
  assign MEM_WDATA = wdata_q;
  assign MEM_WRITE = we_q;
  assign PROGRAM_WRITE_STROBE_MODE_ACTIVE = active;
  assign LOCK_BITS = lock_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_OE_READ_ONLY: assert property (@(posedge CLK) disable iff (!NRST)
    DATA_BUS_PORT_OE |-> active && !PROGRAM_READ_STROBE_N && mode_q != opp_pkg::MODE_RSVD)
    else $error("Port 0 driven outside a read");
  AST_NO_ACCESS_BEFORE_ENTRY: assert property (@(posedge CLK) disable iff (!NRST)
    !active |-> !DATA_BUS_PORT_OE ##1 !MEM_WRITE)
    else $error("Access outside programming mode");
  AST_ENTRY_LENGTH: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(active) |-> $past(state_q) == opp_pkg::ST_ENTRY && $past(cnt_q) == opp_pkg::ENTRY_CNT_MAX)
    else $error("Mode entered without full entry time");
  AST_WRITE_CAUSE: assert property (@(posedge CLK) disable iff (!NRST)
    MEM_WRITE |-> $past(wr_fire) && $past(mode_q) == opp_pkg::MODE_MEM && MEM_WDATA == $past(DATA_BUS_PORT_IN))
    else $error("Array write without a memory write strobe");
  AST_WRITE_PULSE: assert property (@(posedge CLK) disable iff (!NRST)
    MEM_WRITE |=> !MEM_WRITE)
    else $error("Array write longer than one cycle");
  AST_RSVD_IGNORED: assert property (@(posedge CLK) disable iff (!NRST)
    stb_fall[opp_pkg::STB_WR] && mode_q == opp_pkg::MODE_RSVD |=> !MEM_WRITE && $stable(lock_q))
    else $error("Reserved code modified storage");
  AST_LOCK_ONLY_CLEARS: assert property (@(posedge CLK) disable iff (!NRST)
    (lock_q & ~$past(lock_q)) == 2'h0)
    else $error("Lock bit returned to unprogrammed");
  AST_LOCK_READ: assert property (@(posedge CLK) disable iff (!NRST)
    active && PROGRAM_READ_STROBE_N && mode_q == opp_pkg::MODE_LOCK |=> DATA_BUS_PORT_OUT == {6'h00, $past(lock_q)})
    else $error("Lock read shows wrong bits");
  AST_READ_STEADY: assert property (@(posedge CLK) disable iff (!NRST)
    DATA_BUS_PORT_OE && $past(DATA_BUS_PORT_OE) |-> $stable(DATA_BUS_PORT_OUT))
    else $error("Read data moved during strobe");
  AST_HIGH_ADDR: assert property (@(posedge CLK) disable iff (!NRST)
    active && stb_fall[opp_pkg::STB_ALE] ##1 active |=> MEM_ADDR[13:8] == $past(ADDRESS_BUS_PORT[5:0], 2))
    else $error("High address not latched");
  AST_EXIT: assert property (@(posedge CLK) disable iff (!NRST)
    active && !RESET_PIN |=> state_q == opp_pkg::ST_IDLE)
    else $error("Mode kept after reset pin dropped");

  COV_ENTRY: cover property (@(posedge CLK) disable iff (!NRST) $rose(active));
  COV_MEM_WRITE: cover property (@(posedge CLK) disable iff (!NRST) MEM_WRITE);
  COV_LOCK_WRITE: cover property (@(posedge CLK) disable iff (!NRST) wr_fire && mode_q == opp_pkg::MODE_LOCK);
  COV_VER_READ: cover property (@(posedge CLK) disable iff (!NRST)
    DATA_BUS_PORT_OE && mode_q == opp_pkg::MODE_VERSION);

endmodule
`default_nettype wire

// >>> verification/opp_port_tb_top.sv
// Self-checking testbench for the programming port
`timescale 1ns/10ps
`default_nettype none
module opp_port_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  wire logic rst_pin, fetch, vpin, vhigh, sel_lo, sel_hi, ale, wr_n, rd_n, pdrv, oe, mwr, act;
  wire logic [7:0] addr, pdata, bus, dout, wdata, rdata;
  wire logic [13:0] maddr;
  wire logic [1:0] lock;
  logic [7:0] idle_q = 8'h00; // Undriven bus shows the inverse of its last value
  logic [7:0] mem [0:16383]; // Erased array, all ones
  int wcnt = 0;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] rv;
  logic roe;

  always #12.5 clk = ~clk;
  assign bus = oe ? dout : (pdrv ? pdata : idle_q);
  always @(posedge clk) idle_q <= ~bus;
  assign rdata = mem[maddr];
  // Array model with one-time semantics: bits only clear
  always @(posedge clk) begin
    if (mwr === 1'b1) begin
      mem[maddr] <= mem[maddr] & wdata;
      wcnt <= wcnt + 1;
    end
  end
  initial for (int i = 0; i < 16384; i++) mem[i] = 8'hff;

  opp_program_write_strobe_model program_write_strobe (.clk(clk), .bus(bus), .dev_oe(oe), .rst_pin(rst_pin), .fetch(fetch),
    .vpin(vpin), .vhigh(vhigh), .sel_lo(sel_lo), .sel_hi(sel_hi), .ale(ale), .wr_n(wr_n),
    .rd_n(rd_n), .addr(addr), .pdata(pdata), .pdrv(pdrv));
  opp_port dut (.CLK(clk), .NRST(nrst), .RESET_PIN(rst_pin), .CODE_FETCH_STROBE_PIN(fetch),
    .PROGRAMMING_VOLTAGE_PIN(vpin), .PROGRAMMING_VOLTAGE_HIGH(vhigh), .ACCESS_SELECT_LOW(sel_lo),
    .ACCESS_SELECT_HIGH(sel_hi), .HIGH_ADDRESS_LATCH_STROBE(ale), .PROGRAM_WRITE_STROBE_N(wr_n),
    .PROGRAM_READ_STROBE_N(rd_n), .ADDRESS_BUS_PORT(addr), .DATA_BUS_PORT_IN(bus),
    .DATA_BUS_PORT_OUT(dout), .DATA_BUS_PORT_OE(oe), .MEM_ADDR(maddr), .MEM_WDATA(wdata),
    .MEM_WRITE(mwr), .MEM_RDATA(rdata), .PROGRAM_WRITE_STROBE_MODE_ACTIVE(act), .LOCK_BITS(lock));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Entry with its hold time checked on both sides
  task automatic go_active();
    program_write_strobe.entry_set();
    // First edge sees the levels, then the full hold count
    repeat (opp_pkg::ENTRY_CYCLES) @(posedge clk);
    #1;
    chk("active early", act, 0);
    @(posedge clk);
    #1;
    chk("active", act, 1);
    program_write_strobe.entry_end();
  endtask
  task automatic t_reset();
    #1;
    chk("oe", oe, 0);
    chk("mem write", mwr, 0);
    chk("active", act, 0);
    chk("lock", lock, 2'h3);
    $display("Test reset done");
  endtask
  // Entry cut short, and a write outside the mode
  task automatic t_abort();
    program_write_strobe.wr(8'h10, 8'h00);
    chk("write count", wcnt, 0);
    program_write_strobe.entry_set();
    repeat (20) @(posedge clk);
    program_write_strobe.entry_end();
    repeat (50) @(posedge clk);
    #1;
    chk("active", act, 0);
    $display("Test abort done");
  endtask
  task automatic t_mem();
    program_write_strobe.sel(2'b11, 6'h15);
    program_write_strobe.wr(8'h3c, 8'ha5);
    chk("write count", wcnt, 1);
    chk("mem byte", mem[14'h153c], 8'ha5);
    program_write_strobe.rd(8'h3c, rv, roe);
    chk("read oe", roe, 1);
    chk("read byte", rv, 8'ha5);
    program_write_strobe.rd(8'h3d, rv, roe);
    chk("erased byte", rv, 8'hff);
    #1;
    chk("oe after read", oe, 0);
    $display("Test memory done");
  endtask
  task automatic t_lock();
    program_write_strobe.sel(2'b10, 6'h00);
    program_write_strobe.wr(8'h00, 8'hfe);
    chk("lock", lock, 2'h2);
    program_write_strobe.rd(8'h00, rv, roe);
    chk("lock read", rv, 8'h02);
    chk("read oe", roe, 1);
    program_write_strobe.wr(8'h00, 8'hfd);
    chk("lock", lock, 2'h0);
    chk("write count", wcnt, 1);
    program_write_strobe.rd(8'h00, rv, roe);
    chk("lock read", rv, 8'h00);
    $display("Test lock done");
  endtask
  task automatic t_version();
    logic [7:0] exp [3];
    exp = '{opp_pkg::VER_BYTE0, opp_pkg::VER_BYTE1, opp_pkg::VER_BYTE2};
    program_write_strobe.sel(2'b01, 6'h00);
    program_write_strobe.wr(8'hfc, 8'h00);
    chk("write count", wcnt, 1);
    for (int i = 0; i < 3; i++) begin
      program_write_strobe.rd(opp_pkg::VER_ADDR0 + 8'(i), rv, roe);
      chk("version", rv, exp[i]);
      chk("version oe", roe, 1);
    end
    chk("lock", lock, 2'h0);
    $display("Test version done");
  endtask
  task automatic t_rsvd();
    program_write_strobe.sel(2'b00, 6'h15);
    program_write_strobe.wr(8'h3c, 8'h00);
    chk("write count", wcnt, 1);
    chk("mem byte", mem[14'h153c], 8'ha5);
    program_write_strobe.rd(8'h3c, rv, roe);
    chk("read oe", roe, 0);
    $display("Test reserved done");
  endtask
  // Leaving the mode through each hold pin
  task automatic t_exit();
    for (int k = 0; k < 2; k++) begin
      // Still in the mode from the earlier tests on the first pass
      if (k > 0) begin
        go_active();
      end
      program_write_strobe.sel(2'b11, 6'h15);
      program_write_strobe.pin_exit(k[0]);
      repeat (3) @(posedge clk);
      #1;
      chk("active", act, 0);
      program_write_strobe.wr(8'h3c, 8'h00);
      chk("write count", wcnt, 1);
      chk("lock", lock, 2'h0);
    end
    $display("Test exit done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_abort();
    go_active();
    t_mem();
    t_lock();
    t_version();
    t_rsvd();
    t_exit();
    stop_test();
  end
endmodule
`default_nettype wire

// >>> verification/opp_program_write_strobe_model.sv
// Behavioural programmer that drives the device's programming pins
`timescale 1ns/10ps
`default_nettype none
module opp_program_write_strobe_model (
  // Clock
  input wire logic clk,
  // Device view
  input wire logic [7:0] bus,
  input wire logic dev_oe,
  // Mode entry pins
  output logic rst_pin,
  output logic fetch,
  output logic vpin,
  output logic vhigh,
  // Access control pins
  output logic sel_lo,
  output logic sel_hi,
  output logic ale,
  output logic wr_n,
  output logic rd_n,
  // Address and data
  output logic [7:0] addr,
  output logic [7:0] pdata,
  output logic pdrv
);
  // ----------------------------------------------------------------
  // Pin sequences
  // ----------------------------------------------------------------
  // Idle levels; read and write strobes high, latch strobe low, so release of reset sees no edge
  initial begin
    rst_pin = 1'b1; fetch = 1'b0; vpin = 1'b1; vhigh = 1'b0;
    sel_lo = 1'b0; sel_hi = 1'b0; ale = 1'b0; wr_n = 1'b1; rd_n = 1'b1;
    addr = 8'h00; pdata = 8'h00; pdrv = 1'b0;
  end
  // Apply entry levels and keep them
  task automatic entry_set();
    @(posedge clk);
    rst_pin <= 1'b1;
    fetch <= 1'b0;
    wr_n <= 1'b0;
    vpin <= 1'b0;
    vhigh <= 1'b0;
  endtask
  // Leave entry levels; write strobe idles high again
  task automatic entry_end();
    @(posedge clk);
    wr_n <= 1'b1;
    vpin <= 1'b1;
  endtask
  // Select only while the latch strobe is low
  task automatic sel(input logic [1:0] m, input logic [5:0] hi);
    @(posedge clk);
    sel_hi <= m[1];
    sel_lo <= m[0];
    addr <= {2'h0, hi};
    @(posedge clk);
    ale <= 1'b1;
    @(posedge clk);
    ale <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // One write pulse with high voltage applied
  task automatic wr(input logic [7:0] lo, input logic [7:0] d);
    @(posedge clk);
    addr <= lo;
    pdata <= d;
    pdrv <= 1'b1;
    vhigh <= 1'b1;
    repeat (2) @(posedge clk);
    wr_n <= 1'b0;
    @(posedge clk);
    wr_n <= 1'b1;
    @(posedge clk);
    pdrv <= 1'b0;
    vhigh <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // One read pulse; bus released by the programmer first
  task automatic rd(input logic [7:0] lo, output logic [7:0] d, output logic oe);
    @(posedge clk);
    addr <= lo;
    pdrv <= 1'b0;
    repeat (3) @(posedge clk);
    rd_n <= 1'b0;
    @(posedge clk);
    #1;
    d = bus;
    oe = dev_oe;
    @(posedge clk);
    rd_n <= 1'b1;
    @(posedge clk);
  endtask
  // Break a mode-hold pin to leave programming mode
  task automatic pin_exit(input logic use_rst);
    @(posedge clk);
    if (use_rst) begin
      rst_pin <= 1'b0;
    end else begin
      fetch <= 1'b1;
    end
  endtask
endmodule
`default_nettype wire
